// >>> tbt_error_tally.sv
// Saturating self-test error counter.
`timescale 1ns/1ps
`default_nettype none
module tbt_error_tally #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  tbt_tally_if.owner tif
);
  import tbt_pkg::*;
  localparam logic [W-1:0] MAX = '1;
  initial begin
    if (W < 1) $error("tally width must be positive");
  end
  assign tif.saturated = (tif.count == MAX);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tif.count <= '0;
    end else if (tif.restart) begin
      tif.count <= '0;
    end else if (tif.nibble_err && !tif.saturated) begin
      tif.count <= tif.count + {{(W-1){1'b0}}, 1'b1};
    end
  end
  // Apart from a restart, holding at the top value is the only thing that stops a count.
  a_tally_no_wrap: assert property (@(posedge clk) disable iff (!nrst)
    $past(tif.count) == MAX && !$past(tif.restart) |-> tif.count == MAX)
    else $error("tally wrapped");
  a_tally_restart: assert property (@(posedge clk) disable iff (!nrst)
    tif.restart |=> tif.count == '0)
    else $error("tally not cleared");
endmodule : tbt_error_tally
`default_nettype wire

// >>> tbt_pkg.sv
// Constants, types and the behaviour overview for the 10BASE-T test and self-test block.
// Overview of operation
// - In half-duplex 10 Mb/s, heartbeat is off when heartbeat_off is 1.
// - At 100 Mb/s or full duplex heartbeat stays off, heartbeat_off ignored.
// - jabber_guard_off acts only in 10BASE-T; 1 disables jabber, 0 keeps it.
// - Errored self-test nibbles are counted in read-only bits 15 to 8.
// - The error tally returns to zero when packet self-test restarts.
// - The error tally saturates at its maximum and never wraps.
// - selftest_continuous at bit 5 sends gapless pseudo-random data with self-test.
// - Bit 4 enables the 10 Mb/s line driver test pattern when 1.
// - Pattern gap is 15 us when pattern_gap_select is 1, else 10 us.
// - Pattern choice: 00 data/type0, 01 data/type1, 10 link pulses, 11 tone.
package tbt_pkg;
  localparam logic [4:0] ADDR_SERIAL_CONFIG = 5'h1A;
  localparam logic [4:0] ADDR_DRIVER_TEST = 5'h1B;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h1E;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h1F;
  localparam int BIT_JABBER_OFF = 0;
  localparam int BIT_HEARTBEAT_OFF = 1;
  localparam int BIT_SER_RSVD_ONE = 2;
  localparam int BIT_PAT_GAP = 2;
  localparam int BIT_PAT_ON = 4;
  localparam int BIT_CONT = 5;
  localparam int TALLY_LSB = 8;
  localparam int TALLY_W = 8;
  localparam logic [15:0] SERIAL_RESET = 16'h0004;
  localparam logic [15:0] DRIVER_TEST_RESET = 16'h0000;
  localparam logic [15:0] SERIAL_WMASK = 16'h0007;
  localparam logic [15:0] DRIVER_WMASK = 16'h00FF;
  // Interrupt event bits.
  localparam int IRQ_ERR = 0;
  localparam int IRQ_SAT = 1;
  localparam int IRQ_W = 2;
  localparam int CLK_MHZ = 10;
  localparam int GAP_LONG_US = 15;
  localparam int GAP_SHORT_US = 10;
  localparam int GAP_LONG_CYC = GAP_LONG_US * CLK_MHZ;
  localparam int GAP_SHORT_CYC = GAP_SHORT_US * CLK_MHZ;
  localparam int GAP_CNT_W = 8;
  typedef enum logic [1:0] {
    TBT_PAT_DATA_END_PACKET_TYPE0,
    TBT_PAT_DATA_END_PACKET_TYPE1,
    TBT_PAT_LINK_PULSE,
    TBT_PAT_TONE
  } tbt_pattern_type;
  typedef enum {
    TBT_TX_NORMAL,
    TBT_TX_SEQUENCE,
    TBT_TX_GAP,
    TBT_TX_TONE,
    TBT_TX_CONT
  } tbt_tx_state_type;
endpackage : tbt_pkg

// >>> tbt_tally_if.sv
// Interface between the top and the error tally.
`timescale 1ns/1ps
`default_nettype none
interface tbt_tally_if #(parameter int W = 8);
  logic restart;
  logic nibble_err;
  logic [W-1:0] count;
  logic saturated;
  modport owner (input restart, input nibble_err, output count, output saturated);
  modport user (output restart, output nibble_err, input count, input saturated);
endinterface : tbt_tally_if
`default_nettype wire

// >>> tbt_test_ctrl.sv
// Top: 10BASE-T test controls, pattern sequencer and self-test error tally.
`timescale 1ns/1ps
`default_nettype none
module tbt_test_ctrl #(
  parameter int TALLY_WIDTH = tbt_pkg::TALLY_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic selftest_start,
  input wire logic selftest_active,
  input wire logic nibble_err,
  output logic heartbeat_en,
  output logic jabber_en,
  output logic cont_prbs,
  output logic pattern_active,
  output logic pattern_seq,
  output logic [1:0] pattern_kind,
  output logic tone_out,
  output logic irq
);
  import tbt_pkg::*;
  initial begin
    if (TALLY_WIDTH != TALLY_W) $error("tally must fill bits 15 to 8");
  end
  logic [15:0] serial_cfg;
  logic [7:0] driver_ctl;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [GAP_CNT_W-1:0] gap_cnt;
  logic [GAP_CNT_W-1:0] seq_cnt;
  logic saturated_d;
  tbt_tx_state_type tx_state;
  tbt_tally_if #(.W(TALLY_WIDTH)) tif ();
  tbt_error_tally #(.W(TALLY_WIDTH)) u_tally (
    .clk(clk),
    .nrst(nrst),
    .tif(tif)
  );
  assign tif.restart = selftest_start;
  assign tif.nibble_err = nibble_err && selftest_active;
  wire logic pat_on = driver_ctl[BIT_PAT_ON];
  wire logic long_gap = driver_ctl[BIT_PAT_GAP];
  wire tbt_pattern_type choice = tbt_pattern_type'(driver_ctl[1:0]);
  wire logic [15:0] driver_word = {tif.count, driver_ctl};
  wire logic wr_serial = reg_wr && reg_addr == ADDR_SERIAL_CONFIG;
  wire logic wr_driver = reg_wr && reg_addr == ADDR_DRIVER_TEST;
  wire logic wr_status = reg_wr && reg_addr == ADDR_IRQ_STATUS;
  wire logic wr_mask = reg_wr && reg_addr == ADDR_IRQ_MASK;
  // reserved bit stored as written; software is relied on to keep it one.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      serial_cfg <= SERIAL_RESET;
    end else if (wr_serial) begin
      serial_cfg <= reg_wdata & SERIAL_WMASK;
    end
  end
  // reserved bits are stored as written, since they read back as RW.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      driver_ctl <= DRIVER_TEST_RESET[7:0];
    end else if (wr_driver) begin
      driver_ctl <= reg_wdata[7:0] & DRIVER_WMASK[7:0];
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_SERIAL_CONFIG: reg_rdata <= serial_cfg;
        // tally reads in bits 15 to 8
        ADDR_DRIVER_TEST: reg_rdata <= driver_word;
        ADDR_IRQ_STATUS: reg_rdata <= {{(16-IRQ_W){1'b0}}, irq_status};
        ADDR_IRQ_MASK: reg_rdata <= {{(16-IRQ_W){1'b0}}, irq_mask};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
  // Events: an error during self-test, and the tally reaching saturation; set beats clear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      saturated_d <= 1'b0;
    end else begin
      saturated_d <= tif.saturated;
    end
  end
  wire logic [IRQ_W-1:0] irq_events = {tif.saturated && !saturated_d, tif.nibble_err};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~(wr_status ? reg_wdata[IRQ_W-1:0] : '0)) | irq_events;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask <= '0;
    end else if (wr_mask) begin
      irq_mask <= reg_wdata[IRQ_W-1:0];
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end
  // heartbeat only in half-duplex 10 Mb/s
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      heartbeat_en <= 1'b0;
    end else begin
      heartbeat_en <= !speed_100 && !full_duplex && !serial_cfg[BIT_HEARTBEAT_OFF];
    end
  end
  // jabber guard only matters at 10 Mb/s
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      jabber_en <= 1'b0;
    end else begin
      jabber_en <= !speed_100 && !serial_cfg[BIT_JABBER_OFF];
    end
  end
  // gapless pseudo-random data alongside the self-test run
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cont_prbs <= 1'b0;
    end else begin
      cont_prbs <= driver_ctl[BIT_CONT] && selftest_active;
    end
  end
  // The sequence burst length is not given; one gap length is used for it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_state <= TBT_TX_NORMAL;
      gap_cnt <= '0;
      seq_cnt <= '0;
    end else begin
      unique case (tx_state)
        TBT_TX_NORMAL: begin
          // pattern enable selects the test output
          if (pat_on) begin
            tx_state <= (choice == TBT_PAT_TONE) ? TBT_TX_TONE : TBT_TX_SEQUENCE;
            seq_cnt <= GAP_CNT_W'(GAP_SHORT_CYC - 1);
          end else if (cont_prbs) begin
            tx_state <= TBT_TX_CONT;
          end
        end
        TBT_TX_SEQUENCE: begin
          if (!pat_on) begin
            tx_state <= TBT_TX_NORMAL;
          end else if (seq_cnt == '0) begin
            tx_state <= TBT_TX_GAP;
            gap_cnt <= long_gap ? GAP_CNT_W'(GAP_LONG_CYC - 1) :
                                  GAP_CNT_W'(GAP_SHORT_CYC - 1);
          end else begin
            seq_cnt <= seq_cnt - 1'b1;
          end
        end
        TBT_TX_GAP: begin
          if (!pat_on) begin
            tx_state <= TBT_TX_NORMAL;
          end else if (gap_cnt == '0) begin
            tx_state <= (choice == TBT_PAT_TONE) ? TBT_TX_TONE : TBT_TX_SEQUENCE;
            seq_cnt <= GAP_CNT_W'(GAP_SHORT_CYC - 1);
          end else begin
            gap_cnt <= gap_cnt - 1'b1;
          end
        end
        TBT_TX_TONE: begin
          if (!pat_on || choice != TBT_PAT_TONE) begin
            tx_state <= TBT_TX_NORMAL;
          end
        end
        TBT_TX_CONT: begin
          if (pat_on || !cont_prbs) begin
            tx_state <= TBT_TX_NORMAL;
          end
        end
      endcase
    end
  end
  // kind follows the choice only while a pattern runs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pattern_active <= 1'b0;
      pattern_seq <= 1'b0;
      pattern_kind <= 2'h0;
    end else begin
      pattern_active <= pat_on;
      pattern_seq <= (tx_state == TBT_TX_SEQUENCE);
      pattern_kind <= pat_on ? driver_ctl[1:0] : 2'h0;
    end
  end
  // Constant Manchester ones at the 10 MHz clock give a half-rate square; a toggle suffices.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tone_out <= 1'b0;
    end else begin
      tone_out <= (tx_state == TBT_TX_TONE) ? !tone_out : 1'b0;
    end
  end
  a_heartbeat_gate: assert property (@(posedge clk) disable iff (!nrst)
    (speed_100 || full_duplex) |=> !heartbeat_en)
    else $error("heartbeat on at 100M or full duplex");
  a_heartbeat_bit: assert property (@(posedge clk) disable iff (!nrst)
    !speed_100 && !full_duplex && serial_cfg[BIT_HEARTBEAT_OFF] |=> !heartbeat_en)
    else $error("heartbeat not suppressed");
  a_jabber_bit: assert property (@(posedge clk) disable iff (!nrst)
    nrst && !speed_100 |=> jabber_en == !$past(serial_cfg[BIT_JABBER_OFF]))
    else $error("jabber enable wrong");
  a_tally_counts: assert property (@(posedge clk) disable iff (!nrst)
    tif.nibble_err && !tif.saturated && !selftest_start
      |=> tif.count == $past(tif.count) + 1'b1)
    else $error("error not counted");
  a_cont_mode: assert property (@(posedge clk) disable iff (!nrst)
    driver_ctl[BIT_CONT] && selftest_active |=> cont_prbs)
    else $error("continuous mode missing");
  a_pattern_off: assert property (@(posedge clk) disable iff (!nrst)
    !pat_on |=> !pattern_active && pattern_kind == 2'h0)
    else $error("pattern active while disabled");
  a_pattern_kind: assert property (@(posedge clk) disable iff (!nrst)
    pat_on |=> pattern_active && pattern_kind == $past(driver_ctl[1:0]))
    else $error("pattern choice not followed");
  sequence s_gap_enter;
    tx_state == TBT_TX_SEQUENCE && pat_on && seq_cnt == '0 && !long_gap;
  endsequence
  a_short_gap: assert property (@(posedge clk) disable iff (!nrst)
    s_gap_enter ##1 (pat_on && !long_gap)[*1] |-> gap_cnt == GAP_CNT_W'(GAP_SHORT_CYC - 1))
    else $error("short gap length wrong");
  // Heartbeat and jabber follow the serial config one edge later.
  a_heartbeat_on: assert property (@(posedge clk) disable iff (!nrst)
    nrst && !speed_100 && !full_duplex && !serial_cfg[BIT_HEARTBEAT_OFF] |=> heartbeat_en)
    else $error("heartbeat missing in half-duplex 10M");
  a_jabber_off: assert property (@(posedge clk) disable iff (!nrst)
    serial_cfg[BIT_JABBER_OFF] |=> !jabber_en)
    else $error("jabber on although disabled");
  a_jabber_fast: assert property (@(posedge clk) disable iff (!nrst)
    speed_100 |=> !jabber_en)
    else $error("jabber on at 100M");
  // The tally moves only on a counted error or a restart.
  a_tally_idle: assert property (@(posedge clk) disable iff (!nrst)
    !tif.nibble_err && !tif.restart |=> $stable(tif.count))
    else $error("tally moved without an error");
  a_tally_hold: assert property (@(posedge clk) disable iff (!nrst)
    tif.saturated && !tif.restart |=> tif.saturated)
    else $error("tally left full count");
  a_restart_wins: assert property (@(posedge clk) disable iff (!nrst)
    tif.restart && tif.nibble_err |=> tif.count == '0)
    else $error("error beat the restart");
  a_tally_read: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == ADDR_DRIVER_TEST |=> reg_rdata[TALLY_LSB +: TALLY_W] == $past(tif.count))
    else $error("tally not in the upper byte");
  a_cont_off: assert property (@(posedge clk) disable iff (!nrst)
    !driver_ctl[BIT_CONT] || !selftest_active |=> !cont_prbs)
    else $error("continuous mode without its bit");
  a_cont_state: assert property (@(posedge clk) disable iff (!nrst)
    tx_state == TBT_TX_NORMAL && !pat_on && cont_prbs |=> tx_state == TBT_TX_CONT)
    else $error("continuous transmission not entered");
  // Pattern sequencing: entry, burst count, gap count and exit.
  sequence s_tone_pick;
    tx_state == TBT_TX_NORMAL && pat_on && choice == TBT_PAT_TONE;
  endsequence
  sequence s_seq_pick;
    tx_state == TBT_TX_NORMAL && pat_on && choice != TBT_PAT_TONE;
  endsequence
  sequence s_gap_enter_long;
    tx_state == TBT_TX_SEQUENCE && pat_on && seq_cnt == '0 && long_gap;
  endsequence
  sequence s_gap_tick;
    tx_state == TBT_TX_GAP && pat_on && gap_cnt != '0;
  endsequence
  sequence s_seq_tick;
    tx_state == TBT_TX_SEQUENCE && pat_on && seq_cnt != '0;
  endsequence
  a_tone_entry: assert property (@(posedge clk) disable iff (!nrst)
    s_tone_pick |=> tx_state == TBT_TX_TONE)
    else $error("tone not started");
  a_seq_entry: assert property (@(posedge clk) disable iff (!nrst)
    s_seq_pick |=> tx_state == TBT_TX_SEQUENCE && seq_cnt == GAP_CNT_W'(GAP_SHORT_CYC - 1))
    else $error("sequence not started");
  a_seq_count: assert property (@(posedge clk) disable iff (!nrst)
    s_seq_tick |=> tx_state == TBT_TX_SEQUENCE && seq_cnt == $past(seq_cnt) - 1'b1)
    else $error("sequence burst cut short");
  a_long_gap: assert property (@(posedge clk) disable iff (!nrst)
    s_gap_enter_long |=> tx_state == TBT_TX_GAP && gap_cnt == GAP_CNT_W'(GAP_LONG_CYC - 1))
    else $error("long gap length wrong");
  a_gap_count: assert property (@(posedge clk) disable iff (!nrst)
    s_gap_tick |=> tx_state == TBT_TX_GAP && gap_cnt == $past(gap_cnt) - 1'b1)
    else $error("gap cut short");
  a_gap_end: assert property (@(posedge clk) disable iff (!nrst)
    tx_state == TBT_TX_GAP && pat_on && gap_cnt == '0 |=> tx_state != TBT_TX_GAP)
    else $error("gap overran");
  a_pattern_exit: assert property (@(posedge clk) disable iff (!nrst)
    !pat_on |=> tx_state == TBT_TX_NORMAL || tx_state == TBT_TX_CONT)
    else $error("pattern kept running while disabled");
  a_seq_flag_on: assert property (@(posedge clk) disable iff (!nrst)
    tx_state == TBT_TX_SEQUENCE |=> pattern_seq)
    else $error("sequence flag missing");
  a_seq_flag_off: assert property (@(posedge clk) disable iff (!nrst)
    tx_state != TBT_TX_SEQUENCE |=> !pattern_seq)
    else $error("sequence flag outside a sequence");
  a_tone_toggle: assert property (@(posedge clk) disable iff (!nrst)
    tx_state == TBT_TX_TONE |=> tone_out != $past(tone_out))
    else $error("tone stalled");
  a_tone_quiet: assert property (@(posedge clk) disable iff (!nrst)
    tx_state != TBT_TX_TONE |=> !tone_out)
    else $error("tone outside tone mode");
  // Register port and interrupt bookkeeping.
  a_rdata_idle: assert property (@(posedge clk) disable iff (!nrst)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_rdata_serial: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == ADDR_SERIAL_CONFIG |=> reg_rdata == $past(serial_cfg))
    else $error("serial config read wrong");
  a_mask_write: assert property (@(posedge clk) disable iff (!nrst)
    wr_mask |=> irq_mask == $past(reg_wdata[IRQ_W-1:0]))
    else $error("mask write lost");
  a_status_set: assert property (@(posedge clk) disable iff (!nrst)
    tif.nibble_err |=> irq_status[IRQ_ERR])
    else $error("error event lost");
  a_status_sat: assert property (@(posedge clk) disable iff (!nrst)
    tif.saturated && !saturated_d |=> irq_status[IRQ_SAT])
    else $error("saturation event lost");
  a_status_hold: assert property (@(posedge clk) disable iff (!nrst)
    irq_status[IRQ_ERR] && !wr_status |=> irq_status[IRQ_ERR])
    else $error("status bit dropped");
  a_status_clear: assert property (@(posedge clk) disable iff (!nrst)
    wr_status && reg_wdata[IRQ_ERR] && !tif.nibble_err |=> !irq_status[IRQ_ERR])
    else $error("status bit not cleared");
  a_irq_level: assert property (@(posedge clk) disable iff (!nrst)
    |(irq_status & irq_mask) |=> irq)
    else $error("interrupt missing");
  a_irq_quiet: assert property (@(posedge clk) disable iff (!nrst)
    !(|(irq_status & irq_mask)) |=> !irq)
    else $error("interrupt without cause");
endmodule : tbt_test_ctrl
`default_nettype wire

// >>> test_tbt_test_ctrl.sv
// Self-checking testbench for the 10BASE-T test and self-test control block.
`timescale 1ns/1ps
`default_nettype none
module test_tbt_test_ctrl;
  import tbt_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic speed_100 = 1'b0;
  logic full_duplex = 1'b0;
  logic selftest_start = 1'b0;
  logic selftest_active = 1'b0;
  logic nibble_err = 1'b0;
  logic heartbeat_en, jabber_en, cont_prbs, pattern_active, pattern_seq, tone_out, irq;
  logic [1:0] pattern_kind;
  int bad_count = 0;
  int total_checks = 0;

  always #50 clk = ~clk;

  tbt_test_ctrl i_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .speed_100(speed_100),
    .full_duplex(full_duplex), .selftest_start(selftest_start),
    .selftest_active(selftest_active), .nibble_err(nibble_err), .heartbeat_en(heartbeat_en),
    .jabber_en(jabber_en), .cont_prbs(cont_prbs), .pattern_active(pattern_active),
    .pattern_seq(pattern_seq), .pattern_kind(pattern_kind), .tone_out(tone_out), .irq(irq));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input string what, input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : rd_chk

  // Control effects land two edges after the write strobe.
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic errs(input int n);
    @(posedge clk);
    nibble_err <= 1'b1;
    repeat (n) @(posedge clk);
    nibble_err <= 1'b0;
    settle();
  endtask : errs

  task automatic restart;
    @(posedge clk);
    selftest_start <= 1'b1;
    @(posedge clk);
    selftest_start <= 1'b0;
    settle();
  endtask : restart

  task automatic t_reset;
    rd_chk("serial config", ADDR_SERIAL_CONFIG, 16'h0004);
    rd_chk("driver test", ADDR_DRIVER_TEST, 16'h0000);
    rd_chk("unmapped", 5'h10, 16'h0000);
    chk("heartbeat_en", 16'h0001, 16'(heartbeat_en));
  endtask : t_reset

  task automatic t_link;
    logic [3:0] i;
    for (int k = 0; k < 16; k++) begin
      i = 4'(k);
      @(posedge clk);
      speed_100 <= i[2];
      full_duplex <= i[3];
      wr(ADDR_SERIAL_CONFIG, {13'h0000, 1'b1, i[0], i[1]});
      settle();
      chk("heartbeat_en", 16'(!i[2] && !i[3] && !i[0]), 16'(heartbeat_en));
      chk("jabber_en", 16'(!i[2] && !i[1]), 16'(jabber_en));
    end
    speed_100 <= 1'b0;
    full_duplex <= 1'b0;
    rd_chk("serial config", ADDR_SERIAL_CONFIG, 16'h0007);
  endtask : t_link

  task automatic t_tally;
    wr(ADDR_IRQ_MASK, 16'h0003);
    selftest_active <= 1'b1;
    restart();
    errs(3);
    rd_chk("tally", ADDR_DRIVER_TEST, 16'h0300);
    chk("irq", 16'h0001, 16'(irq));
    rd_chk("status", ADDR_IRQ_STATUS, 16'h0001);
    wr(ADDR_DRIVER_TEST, 16'hFF00);
    rd_chk("tally", ADDR_DRIVER_TEST, 16'h0300);
    selftest_active <= 1'b0;
    errs(2);
    rd_chk("tally", ADDR_DRIVER_TEST, 16'h0300);
    selftest_active <= 1'b1;
    // Run well past full count so a wrapping counter would show a small value.
    errs(260);
    rd_chk("tally", ADDR_DRIVER_TEST, 16'hFF00);
    rd_chk("status", ADDR_IRQ_STATUS, 16'h0003);
    wr(ADDR_IRQ_STATUS, 16'h0003);
    settle();
    chk("irq", 16'h0000, 16'(irq));
    restart();
    rd_chk("tally", ADDR_DRIVER_TEST, 16'h0000);
    wr(ADDR_IRQ_MASK, 16'h0000);
    errs(1);
    chk("irq", 16'h0000, 16'(irq));
    rd_chk("status", ADDR_IRQ_STATUS, 16'h0001);
    wr(ADDR_IRQ_STATUS, 16'h0001);
  endtask : t_tally

  task automatic t_cont;
    wr(ADDR_SERIAL_CONFIG, 16'h0005);
    wr(ADDR_DRIVER_TEST, 16'h0020);
    settle();
    chk("cont_prbs", 16'h0001, 16'(cont_prbs));
    chk("jabber_en", 16'h0000, 16'(jabber_en));
    selftest_active <= 1'b0;
    settle();
    chk("cont_prbs", 16'h0000, 16'(cont_prbs));
  endtask : t_cont

  task automatic run_len(input logic lvl, output int n);
    n = 0;
    while (pattern_seq !== lvl && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    while (pattern_seq === lvl && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : run_len

  task automatic t_pattern;
    logic t0;
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_DRIVER_TEST, 16'h0010 | 16'(c));
      settle();
      chk("pattern_active", 16'h0001, 16'(pattern_active));
      chk("pattern_kind", 16'(c), 16'(pattern_kind));
    end
    // A running burst finishes before a tone starts, so restart the pattern in tone mode.
    wr(ADDR_DRIVER_TEST, 16'h0000);
    wr(ADDR_DRIVER_TEST, 16'h0013);
    settle();
    t0 = tone_out;
    @(posedge clk);
    #1;
    chk("tone_out", 16'(!t0), 16'(tone_out));
    for (int g = 0; g < 2; g++) begin
      wr(ADDR_DRIVER_TEST, 16'h0010 | 16'(g << 2));
      run_len(1'b0, n);
      run_len(1'b1, n);
      chk("sequence length", 16'd100, 16'(n));
      run_len(1'b0, n);
      chk("gap length", 16'(g ? GAP_LONG_CYC : GAP_SHORT_CYC), 16'(n));
    end
    wr(ADDR_DRIVER_TEST, 16'h0007);
    settle();
    chk("pattern_active", 16'h0000, 16'(pattern_active));
    chk("pattern_kind", 16'h0000, 16'(pattern_kind));
    chk("pattern_seq", 16'h0000, 16'(pattern_seq));
    chk("tone_out", 16'h0000, 16'(tone_out));
  endtask : t_pattern

  task automatic give_verdict;
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    settle();
    t_reset();
    t_link();
    t_tally();
    t_cont();
    t_pattern();
    give_verdict();
  end
endmodule : test_tbt_test_ctrl
`default_nettype wire
